// [interrupt_request_unit.sv]
// request bits of the interrupt sources, set by hardware or by software writes
// assumes hardware requests are one-cycle pulses on the system clock
`default_nettype none

module interrupt_request_unit #(
  parameter int SRC_N = trap_guard_pkg::INT_N,
  parameter int IDX_W = trap_guard_pkg::INT_IDX_W
) (
  // clock and reset
  input  wire  logic             ref_clk,
  input  wire  logic             rst,
  // request sources
  input  wire  logic [SRC_N-1:0] hw_request,
  input  wire  logic             sw_write,
  input  wire  logic [IDX_W-1:0] sw_index,
  input  wire  logic             sw_request_bit,
  // acceptance by the arbiter
  input  wire  logic             take,
  input  wire  logic [IDX_W-1:0] take_index,
  // state
  output logic                   pending_any,
  output logic [IDX_W-1:0]       pending_index,
  output logic [SRC_N-1:0]       request_bits
);

  // ************************************************************
  // request bit update
  // ************************************************************
  logic [SRC_N-1:0] req_q;
  logic [SRC_N-1:0] req_d;
  logic [SRC_N-1:0] sw_sel;
  logic [SRC_N-1:0] take_sel;

  assign sw_sel   = sw_write ? (SRC_N'(1) << sw_index) : '0;
  assign take_sel = take ? (SRC_N'(1) << take_index) : '0;
  // a software set looks exactly like a hardware request; hardware set wins over any clear
  assign req_d = (((req_q & ~take_sel) & ~(sw_sel & {SRC_N{~sw_request_bit}}))
                 | (sw_sel & {SRC_N{sw_request_bit}})) | hw_request;

  always_ff @(posedge ref_clk) begin
    if (rst) req_q <= '0;
    else     req_q <= req_d;
  end

  // ************************************************************
  // lowest index wins
  // ************************************************************
  always_comb begin
    pending_index = '0;
    for (int i = SRC_N - 1; i >= 0; i--) begin
      if (req_q[i]) pending_index = IDX_W'(i);
    end
  end

  assign pending_any  = |req_q;
  assign request_bits = req_q;

endmodule

`default_nettype wire

// [pipeline_model.sv]
// pipeline side of the trap unit: ends service routines and moves request pads
// assumes the bench calls its tasks; pads move just after a clock edge
`default_nettype none

module pipeline_model (
  // clock
  input  wire logic       ref_clk,
  // towards the unit
  output var  logic       service_return,
  output var  logic [2:0] external_service_request
);
  timeunit 1ns;
  timeprecision 100ps;
  // pads idle low, no return pending
  initial begin
    service_return           = 1'b0;
    external_service_request = 3'h0;
  end
  // one-cycle return, as the routine retires its last instruction
  task automatic ret();
    @(posedge ref_clk);
    service_return <= 1'b1;
    @(posedge ref_clk);
    service_return <= 1'b0;
    #1;
  endtask
  // pad change at an edge; the unit still treats it as asynchronous
  task automatic pin(input int idx, input logic lvl);
    @(posedge ref_clk);
    external_service_request[idx] <= lvl;
    #1;
  endtask
endmodule

`default_nettype wire

// [tb_trap_and_stack_guard_unit.sv]
// self-checking bench for the trap and stack guard unit
// assumes pipeline_model for returns and pads; the checker binds itself
`default_nettype none

module tb_trap_and_stack_guard_unit;
  timeunit 1ns;
  timeprecision 100ps;
  // ************************************************************
  // signals
  // ************************************************************
  logic        ref_clk = 1'b0;
  logic        rst, stack_push, stack_pop, icr_write, interrupt_request_bit, trap_instr;
  logic        service_return, cp_write, vector_valid, pec_strobe, trap_service_active;
  logic [23:0] stack_top_pointer, stack_overflow_limit, stack_underflow_limit, cp_value;
  logic [23:0] vector_addr, context_base_pointer, gpr_address;
  logic [1:0]  other_trap;
  logic [5:0]  trap_flag_clear, trap_flag_register;
  logic [2:0]  external_service_request, sr_zero_select, sr_one_select;
  logic [15:0] int_hw_request, peripheral_event_transfer_enable, int_request_bits;
  logic [3:0]  icr_index, pec_channel, gpr_index;
  logic [6:0]  trap_number;
  int          fail_count = 0;
  int          n_compared = 0;

  always #12.5 ref_clk = ~ref_clk;
  trap_and_stack_guard_unit trap_and_stack_guard_unit_i (.*);
  pipeline_model pipeline_model_i (.ref_clk(ref_clk), .service_return(service_return),
    .external_service_request(external_service_request));

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    if (fail_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // one stack access strobe, held through its sampling edge
  task automatic stack_op(input logic push, input logic [23:0] sp);
    @(posedge ref_clk);
    stack_push <= push;
    stack_pop <= !push;
    stack_top_pointer <= sp;
    @(posedge ref_clk);
    stack_push <= 1'b0;
    stack_pop <= 1'b0;
    #1;
  endtask
  // hardware trap, interrupt and flag clear pulses in one cycle
  task automatic hw(input logic [1:0] ot, input logic [15:0] ir, input logic [5:0] clr);
    @(posedge ref_clk);
    other_trap <= ot;
    int_hw_request <= ir;
    trap_flag_clear <= clr;
    @(posedge ref_clk);
    other_trap <= 2'h0;
    int_hw_request <= 16'h0;
    trap_flag_clear <= 6'h0;
    #1;
  endtask
  // trap instruction and request-bit write from the pipeline
  task automatic sw(input logic ins, input logic [6:0] num, input logic wr, input logic [3:0] idx);
    @(posedge ref_clk);
    trap_instr <= ins;
    trap_number <= num;
    icr_write <= wr;
    icr_index <= idx;
    interrupt_request_bit <= 1'b1;
    @(posedge ref_clk);
    trap_instr <= 1'b0;
    icr_write <= 1'b0;
    #1;
  endtask
  // bounded wait for the one-cycle vector, current cycle included
  task automatic wait_vec(input logic [23:0] exp);
    for (int n = 0; n < 10 && vector_valid !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    chk("vector_valid", 24'h1, vector_valid);
    chk("vector_addr", exp, vector_addr);
  endtask
  task automatic no_vec(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      chk("vector_quiet", 24'h0, vector_valid);
    end
  endtask

  // ************************************************************
  // sequence of tests
  // ************************************************************
  initial begin
    rst = 1'b1;
    {stack_push, stack_pop, icr_write, interrupt_request_bit, trap_instr, cp_write} = 6'h00;
    {stack_top_pointer, cp_value, other_trap, trap_flag_clear, int_hw_request} = '0;
    {icr_index, gpr_index, trap_number} = '0;
    stack_overflow_limit = 24'h001000;
    stack_underflow_limit = 24'h002000;
    sr_zero_select = 3'h1;
    sr_one_select = 3'h6;
    peripheral_event_transfer_enable = 16'h0200;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk("flags", 24'h0, trap_flag_register);
    chk("base_pointer", 24'h00FC00, context_base_pointer);
    chk("request_bits", 24'h0, int_request_bits);
    // overflow just above and at the limit, then nesting by priority
    stack_op(1'b1, 24'h001002);
    no_vec(3);
    stack_op(1'b1, 24'h001000);
    chk("flags", 24'h04, trap_flag_register);
    wait_vec(24'h000008);
    chk("trap_active", 24'h1, trap_service_active);
    hw(2'b10, 16'h0008, 6'h04);
    no_vec(4);
    chk("flags", 24'h20, trap_flag_register);
    pipeline_model_i.ret();
    wait_vec(24'h000014);
    hw(2'b01, 16'h0000, 6'h20);
    wait_vec(24'h000010);
    pipeline_model_i.ret();
    wait_vec(24'h00004C);
    chk("request_bits", 24'h0, int_request_bits);
    pipeline_model_i.ret();
    hw(2'b00, 16'h0000, 6'h10);
    // underflow just below and at the limit
    stack_op(1'b0, 24'h001FFE);
    no_vec(3);
    stack_op(1'b0, 24'h002000);
    chk("flags", 24'h08, trap_flag_register);
    wait_vec(24'h00000C);
    pipeline_model_i.ret();
    // span: exactly 32 Kwords deep passes, one word deeper overflows
    @(posedge ref_clk);
    stack_underflow_limit <= 24'h012000;
    stack_op(1'b1, 24'h002000);
    no_vec(3);
    stack_op(1'b1, 24'h001FFE);
    wait_vec(24'h000008);
    pipeline_model_i.ret();
    // software traps just above the interrupt numbers and at the top of the number range
    for (int i = 0; i < 2; i++) begin
      sw(1'b1, (i == 0) ? 7'h20 : 7'h7F, 1'b0, 4'h0);
      wait_vec((i == 0) ? 24'h000080 : 24'h0001FC);
      pipeline_model_i.ret();
    end
    // request bit written by software, then an event transfer source
    sw(1'b0, 7'h00, 1'b1, 4'h7);
    chk("request_bits", 24'h80, int_request_bits);
    wait_vec(24'h00005C);
    pipeline_model_i.ret();
    hw(2'b00, 16'h0200, 6'h00);
    for (int n = 0; n < 6 && pec_strobe !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    chk("pec_strobe", 24'h1, pec_strobe);
    chk("pec_channel", 24'h9, pec_channel);
    chk("vector_valid", 24'h0, vector_valid);
    // service request pads routed to both system requests
    hw(2'b00, 16'h0000, 6'h3F);
    pipeline_model_i.pin(1, 1'b1);
    wait_vec(24'h000004);
    chk("flags", 24'h02, trap_flag_register);
    pipeline_model_i.ret();
    pipeline_model_i.pin(0, 1'b1);
    wait_vec(24'h000000);
    chk("flags", 24'h03, trap_flag_register);
    pipeline_model_i.ret();
    pipeline_model_i.pin(2, 1'b1);
    wait_vec(24'h000004);
    pipeline_model_i.ret();
    // context pointer with odd value, then register 5 and the last register
    @(posedge ref_clk);
    cp_write <= 1'b1;
    cp_value <= 24'h001231;
    gpr_index <= 4'h5;
    @(posedge ref_clk);
    cp_write <= 1'b0;
    #1;
    chk("base_pointer", 24'h001230, context_base_pointer);
    @(posedge ref_clk);
    gpr_index <= 4'hF;
    #1;
    chk("gpr_address", 24'h00123A, gpr_address);
    @(posedge ref_clk);
    #1;
    chk("gpr_address", 24'h00124E, gpr_address);
    stop_test();
  end

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge ref_clk);
    fail_count++;
    stop_test();
  end
endmodule

`default_nettype wire

// [trap_and_stack_guard_unit.sv]
// exception and context logic of the processor: stack guard, trap flags,
// trap and interrupt vectoring, external service requests and context pointer
// assumes pipeline strobes are one-cycle pulses on ref_clk; service request pins are asynchronous
//
// Overview of operation
// - every push compares stack pointer with both limits, every pop with the underflow limit only
// - stack may sit anywhere, reached by pointer, at most 32 Kwords
// - each hardware trap sets its own bit in the trap flags
// - accepted hardware trap branches to its own vector entry
// - hardware trap preempts everything except a trap service of equal or higher priority
// - interrupts and event transfers do not preempt a trap service
// - trap instruction with a number enters that number's service routine
// - software setting a request bit creates a real pending request
// - three service request pins feed two trap-type system requests
// - context holds up to three banks of sixteen word registers
// - context pointer gives bank base for every register access; overlap allowed
`default_nettype none

module trap_and_stack_guard_unit #(
  parameter int ADDR_W = trap_guard_pkg::ADDR_W,
  parameter int INT_N  = trap_guard_pkg::INT_N
) (
  // clock and reset
  input  wire  logic                          ref_clk,
  input  wire  logic                          rst,
  // stack accesses from the pipeline
  input  wire  logic                          stack_push,
  input  wire  logic                          stack_pop,
  input  wire  logic [ADDR_W-1:0]             stack_top_pointer,
  input  wire  logic [ADDR_W-1:0]             stack_overflow_limit,
  input  wire  logic [ADDR_W-1:0]             stack_underflow_limit,
  // other hardware traps from the pipeline
  input  wire  logic [1:0]                    other_trap,
  // trap flags
  input  wire  logic [trap_guard_pkg::TRAP_N-1:0] trap_flag_clear,
  output logic [trap_guard_pkg::TRAP_N-1:0]   trap_flag_register,
  // external service request pins and routing
  input  wire  logic [trap_guard_pkg::ESR_N-1:0] external_service_request,
  input  wire  logic [trap_guard_pkg::ESR_N-1:0] sr_zero_select,
  input  wire  logic [trap_guard_pkg::ESR_N-1:0] sr_one_select,
  // interrupt sources
  input  wire  logic [INT_N-1:0]              int_hw_request,
  input  wire  logic [INT_N-1:0]              peripheral_event_transfer_enable,
  input  wire  logic                          icr_write,
  input  wire  logic [trap_guard_pkg::INT_IDX_W-1:0] icr_index,
  input  wire  logic                          interrupt_request_bit,
  output logic [INT_N-1:0]                    int_request_bits,
  // software trap instruction and return
  input  wire  logic                          trap_instr,
  input  wire  logic [6:0]                    trap_number,
  input  wire  logic                          service_return,
  // vectoring to the pipeline
  output logic                                vector_valid,
  output logic [ADDR_W-1:0]                   vector_addr,
  output logic                                pec_strobe,
  output logic [trap_guard_pkg::INT_IDX_W-1:0] pec_channel,
  output logic                                trap_service_active,
  // register context
  input  wire  logic                          cp_write,
  input  wire  logic [ADDR_W-1:0]             cp_value,
  input  wire  logic [trap_guard_pkg::GPR_IDX_W-1:0] gpr_index,
  output logic [ADDR_W-1:0]                   context_base_pointer,
  output logic [ADDR_W-1:0]                   gpr_address
);

  localparam int TN = trap_guard_pkg::TRAP_N;
  localparam int IW = trap_guard_pkg::INT_IDX_W;
  localparam int TW = trap_guard_pkg::TRAP_IDX_W;
  localparam int GW = trap_guard_pkg::GPR_IDX_W + 1;

  // ************************************************************
  // service request pins: two-stage sync, then edge
  // ************************************************************
  logic [2:0] esr_meta_q;
  logic [2:0] esr_sync_q;
  logic [2:0] esr_prev_q;
  logic [2:0] esr_rise;
  logic       sr_zero;
  logic       sr_one;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      esr_meta_q <= 3'h0;
      esr_sync_q <= 3'h0;
      esr_prev_q <= 3'h0;
    end else begin
      esr_meta_q <= external_service_request;
      esr_sync_q <= esr_meta_q;
      esr_prev_q <= esr_sync_q;
    end
  end

  // each pin may feed either or both system requests
  assign esr_rise = esr_sync_q & ~esr_prev_q;
  assign sr_zero  = |(esr_rise & sr_zero_select);
  assign sr_one   = |(esr_rise & sr_one_select);

  // ************************************************************
  // stack guard, stack grows downward
  // ************************************************************
  logic [ADDR_W-2:0] sp_word;
  logic [ADDR_W-2:0] ovf_word;
  logic [ADDR_W-2:0] unf_word;
  logic [ADDR_W-2:0] depth_words;
  logic              too_deep;
  logic              stk_over;
  logic              stk_under;

  // word compare only; bit 0 of a word stack is not meaningful
  assign sp_word     = stack_top_pointer[ADDR_W-1:1];
  assign ovf_word    = stack_overflow_limit[ADDR_W-1:1];
  assign unf_word    = stack_underflow_limit[ADDR_W-1:1];
  assign depth_words = unf_word - sp_word;
  // any base is allowed, but the span may not pass the largest stack
  assign too_deep    = depth_words > (ADDR_W-1)'(trap_guard_pkg::STACK_WORDS);
  assign stk_over    = stack_push & ((sp_word <= ovf_word) | too_deep);
  assign stk_under   = stack_pop & (sp_word >= unf_word);

  // ************************************************************
  // trap flags and pending traps
  // ************************************************************
  logic [TN-1:0] trap_set;
  logic [TN-1:0] flags_q;
  logic [TN-1:0] pend_q;
  logic [TN-1:0] trap_take_mask;

  assign trap_set[trap_guard_pkg::TRAP_SR0]      = sr_zero;
  assign trap_set[trap_guard_pkg::TRAP_SR1]      = sr_one;
  assign trap_set[trap_guard_pkg::TRAP_STK_OVER] = stk_over;
  assign trap_set[trap_guard_pkg::TRAP_STK_UNDR] = stk_under;
  assign trap_set[trap_guard_pkg::TRAP_EXT_A]    = other_trap[0];
  assign trap_set[trap_guard_pkg::TRAP_EXT_B]    = other_trap[1];

  // set wins over software clear so no trap goes unrecorded
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flags_q <= trap_guard_pkg::FLAGS_RESET;
      pend_q  <= '0;
    end else begin
      flags_q <= (flags_q & ~trap_flag_clear) | trap_set;
      pend_q  <= (pend_q & ~trap_take_mask) | trap_set;
    end
  end

  // ************************************************************
  // arbitration: hardware trap, then trap instruction, then interrupt
  // ************************************************************
  trap_guard_pkg::svc_state_t state_q;
  trap_guard_pkg::svc_state_t state_d;
  logic [TW-1:0] active_q;
  logic [TW-1:0] trap_idx;
  logic          trap_any;
  logic          trap_go;
  logic          instr_go;
  logic          int_go;
  logic          int_any;
  logic [IW-1:0] int_idx;
  logic          int_is_pec;

  always_comb begin
    trap_idx = '0;
    for (int i = TN - 1; i >= 0; i--) begin
      if (pend_q[i]) trap_idx = TW'(i);
    end
  end

  assign trap_any = |pend_q;
  // only a running trap of equal or higher priority holds a new one off
  assign trap_go  = trap_any & ((state_q != trap_guard_pkg::SVC_TRAP)
                   | (trap_idx < active_q));
  assign trap_take_mask = trap_go ? (TN'(1) << trap_idx) : '0;
  assign instr_go = trap_instr & ~trap_go;
  // interrupts and event transfers wait for an idle service state
  assign int_go   = int_any & ~trap_go & ~instr_go
                   & (state_q == trap_guard_pkg::SVC_IDLE);
  assign int_is_pec = peripheral_event_transfer_enable[int_idx];

  always_comb begin
    state_d = state_q;
    case (state_q)
      trap_guard_pkg::SVC_IDLE: begin
        if (trap_go)                       state_d = trap_guard_pkg::SVC_TRAP;
        else if (instr_go)                 state_d = trap_guard_pkg::SVC_INT;
        else if (int_go && !int_is_pec)    state_d = trap_guard_pkg::SVC_INT;
      end
      trap_guard_pkg::SVC_INT: begin
        if (trap_go)             state_d = trap_guard_pkg::SVC_TRAP;
        else if (service_return) state_d = trap_guard_pkg::SVC_IDLE;
      end
      trap_guard_pkg::SVC_TRAP: begin
        // single level kept: return goes back to idle unless a trap is taken in the same cycle
        if (!trap_go && service_return) state_d = trap_guard_pkg::SVC_IDLE;
      end
      default: state_d = trap_guard_pkg::SVC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q  <= trap_guard_pkg::SVC_IDLE;
      active_q <= '0;
    end else begin
      state_q  <= state_d;
      active_q <= trap_go ? trap_idx : active_q;
    end
  end

  interrupt_request_unit #(
    .SRC_N (INT_N),
    .IDX_W (IW)
  ) u_int_req (
    .ref_clk        (ref_clk),
    .rst            (rst),
    .hw_request     (int_hw_request),
    .sw_write       (icr_write),
    .sw_index       (icr_index),
    .sw_request_bit (interrupt_request_bit),
    .take           (int_go),
    .take_index     (int_idx),
    .pending_any    (int_any),
    .pending_index  (int_idx),
    .request_bits   (int_request_bits)
  );

  // ************************************************************
  // vector outputs
  // ************************************************************
  logic [7:0]        vec_num;
  logic              vec_fire;

  assign vec_fire = trap_go | instr_go | (int_go & ~int_is_pec);
  assign vec_num  = trap_go  ? (trap_guard_pkg::TRAP_NUM_0 + {5'h00, trap_idx}) :
                    instr_go ? {1'b0, trap_number} :
                    (trap_guard_pkg::INT_NUM_BASE + {4'h0, int_idx});

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      vector_valid <= 1'b0;
      vector_addr  <= '0;
      pec_strobe   <= 1'b0;
      pec_channel  <= '0;
    end else begin
      vector_valid <= vec_fire;
      vector_addr  <= vec_fire ? trap_guard_pkg::vec_addr(vec_num) : vector_addr;
      pec_strobe   <= int_go & int_is_pec;
      pec_channel  <= (int_go & int_is_pec) ? int_idx : pec_channel;
    end
  end

  assign trap_flag_register  = flags_q;
  assign trap_service_active = state_q[1];

  // ************************************************************
  // register context
  // ************************************************************
  logic [ADDR_W-1:0] cp_q;
  logic [ADDR_W-1:0] gpr_addr_d;

  // banks are just bases in RAM, so overlapping bases are legal by design
  assign gpr_addr_d = cp_q + {{(ADDR_W-GW){1'b0}}, gpr_index, 1'b0};

  // a bank is 16 words; any even base selects one of the banks
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cp_q        <= trap_guard_pkg::CP_RESET;
      gpr_address <= trap_guard_pkg::CP_RESET;
    end else begin
      cp_q        <= cp_write ? {cp_value[ADDR_W-1:1], 1'b0} : cp_q;
      gpr_address <= gpr_addr_d;
    end
  end

  assign context_base_pointer = cp_q;

endmodule

`default_nettype wire

// [trap_guard_asserts.sv]
// concurrent checks on the ports of the trap and stack guard unit
// assumes one clock domain and a synchronous active-high reset; bound below
`default_nettype none

module trap_guard_asserts #(
  parameter int ADDR_W = 24,
  parameter int INT_N  = 16
) (
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              rst,
  // stimulus into the unit
  input wire logic              stack_push,
  input wire logic              stack_pop,
  input wire logic [ADDR_W-1:0] stack_top_pointer,
  input wire logic [ADDR_W-1:0] stack_overflow_limit,
  input wire logic [ADDR_W-1:0] stack_underflow_limit,
  input wire logic [1:0]        other_trap,
  input wire logic [5:0]        trap_flag_clear,
  input wire logic              icr_write,
  input wire logic [3:0]        icr_index,
  input wire logic              interrupt_request_bit,
  input wire logic              trap_instr,
  input wire logic [6:0]        trap_number,
  input wire logic              service_return,
  input wire logic              cp_write,
  input wire logic [ADDR_W-1:0] cp_value,
  input wire logic [3:0]        gpr_index,
  // results of the unit
  input wire logic [5:0]        trap_flag_register,
  input wire logic [INT_N-1:0]  int_request_bits,
  input wire logic              vector_valid,
  input wire logic [ADDR_W-1:0] vector_addr,
  input wire logic              trap_service_active,
  input wire logic [ADDR_W-1:0] context_base_pointer,
  input wire logic [ADDR_W-1:0] gpr_address
);
  // ************************************************************
  // helpers
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [5:0] kept_q;  // flags that must survive the next edge
  always_ff @(posedge ref_clk) kept_q <= trap_flag_register & ~trap_flag_clear;

  // ************************************************************
  // properties
  // ************************************************************
  // stack guard: push at or below one limit, pop at or above the other
  sequence s_push_over;
    stack_push && (stack_top_pointer[ADDR_W-1:1] <= stack_overflow_limit[ADDR_W-1:1]);
  endsequence
  sequence s_pop_under;
    stack_pop && (stack_top_pointer[ADDR_W-1:1] >= stack_underflow_limit[ADDR_W-1:1]);
  endsequence
  // a trap service that began earlier and is not ending or overruled by an instruction
  sequence s_trap_busy;
    $past(trap_service_active) && !$past(service_return) && !$past(trap_instr);
  endsequence
  property p_push_over; s_push_over |=> trap_flag_register[2]; endproperty
  property p_pop_under; s_pop_under |=> trap_flag_register[3]; endproperty
  property p_flag_keep; (trap_flag_register & kept_q) == kept_q; endproperty
  property p_trap_entry;
    $rose(trap_service_active) |-> vector_valid && vector_addr < 24'h18 && vector_addr[1:0] == 2'b00;
  endproperty
  property p_trap_hold; s_trap_busy ##0 vector_valid |-> vector_addr < 24'h18; endproperty
  property p_sw_trap;
    trap_instr && !trap_service_active && !service_return && other_trap == 2'b00 && !stack_push
      && !stack_pop |=> vector_valid && vector_addr == ADDR_W'({$past(trap_number), 2'b00});
  endproperty
  property p_sw_req;
    icr_write && interrupt_request_bit |=> int_request_bits[$past(icr_index)];
  endproperty
  property p_cp; cp_write |=> context_base_pointer == ($past(cp_value) & ~ADDR_W'(1)); endproperty
  property p_gpr;
    !$past(rst) |-> gpr_address == $past(context_base_pointer) + ADDR_W'({$past(gpr_index), 1'b0});
  endproperty
  a_push_over: assert property (p_push_over)
    else $error("overflow flag not raised");
  a_pop_under: assert property (p_pop_under)
    else $error("underflow flag not raised");
  a_flag_keep: assert property (p_flag_keep)
    else $error("trap flag lost without clear");
  a_trap_entry: assert property (p_trap_entry)
    else $error("trap entry without trap vector");
  a_trap_hold: assert property (p_trap_hold)
    else $error("interrupt vector during trap service");
  a_sw_trap: assert property (p_sw_trap)
    else $error("software trap vector wrong");
  a_sw_req: assert property (p_sw_req)
    else $error("written request bit not pending");
  a_cp: assert property (p_cp)
    else $error("context pointer not loaded");
  a_gpr: assert property (p_gpr)
    else $error("register address not pointer based");
endmodule

bind trap_and_stack_guard_unit trap_guard_asserts #(.ADDR_W(ADDR_W), .INT_N(INT_N))
  trap_guard_asserts_i (.*);

`default_nettype wire

// [trap_guard_pkg.sv]
// shared constants, trap numbering and service states for the trap and stack guard
// assumes one system clock and a synchronous, active-high application reset
`default_nettype none

package trap_guard_pkg;

  // ************************************************************
  // widths and sizes
  // ************************************************************
  localparam int ADDR_W      = 24;      // linear address space
  localparam int STACK_WORDS = 32768;   // largest system stack
  localparam int STACK_BYTES = 2 * STACK_WORDS;
  localparam int TRAP_N      = 6;       // hardware trap sources
  localparam int TRAP_IDX_W  = 3;
  localparam int INT_N       = 16;      // interrupt sources
  localparam int INT_IDX_W   = 4;
  localparam int ESR_N       = 3;       // external service request pins
  localparam int GPR_N       = 16;      // registers per bank
  localparam int GPR_IDX_W   = 4;
  localparam int BANK_N      = 3;       // register banks in the context

  // ************************************************************
  // trap sources, index order is priority order (0 highest)
  // ************************************************************
  localparam int TRAP_SR0      = 0;
  localparam int TRAP_SR1      = 1;
  localparam int TRAP_STK_OVER = 2;
  localparam int TRAP_STK_UNDR = 3;
  localparam int TRAP_EXT_A    = 4;
  localparam int TRAP_EXT_B    = 5;

  // ************************************************************
  // vector table: one 4-byte entry per number
  // ************************************************************
  localparam logic [ADDR_W-1:0] VEC_BASE     = 24'h000000;
  localparam logic [7:0]        TRAP_NUM_0   = 8'h00;
  localparam logic [7:0]        INT_NUM_BASE = 8'h10;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [ADDR_W-1:0] CP_RESET    = 24'h00FC00;
  localparam logic [TRAP_N-1:0] FLAGS_RESET = 6'h00;

  // ************************************************************
  // service state, gray along idle -> interrupt -> trap
  // ************************************************************
  typedef enum logic [1:0] {
    SVC_IDLE = 2'b00,
    SVC_INT  = 2'b01,
    SVC_TRAP = 2'b11
  } svc_state_t;

  // byte address of a vector table entry
  function automatic logic [ADDR_W-1:0] vec_addr(input logic [7:0] num);
    vec_addr = VEC_BASE + {{(ADDR_W-10){1'b0}}, num, 2'b00};
  endfunction

endpackage

`default_nettype wire
